// ---- mlm_pkg.sv ----
// package: constants, types and reset table of the lookup multiplier
// How it works
// [RL1] multiplicand input always present, parameter width
// [RL2] multiplicand width 2..8, 16, 24 or 32
// [RL3] multiplicand signed or unsigned by build option
// [RL4] coefficient width 2..8, 16 or 24
// [RL5] one representation for loaded and stored coefficients
// [RL6] first fixed coefficient resets to value 0..4
// [RL7] select input picks stored coefficient to use
// [RL8] load strobe overwrites selected coefficient
// [RL9] load port and strobe exist only when enabled; the code keeps both ports and masks the strobe with LOAD_EN
// [RL10] load done rises once coefficient fully written
// [RL11] loads while load done low are ignored
// [RL12] start strobe begins product, aborts running one; the code still hands over one in its last step if the buffer has room
// [RL13] one cycle per product: start ignored, data every clock
// [RL14] product output always present, product width
// [RL15] product valid only with completed product
// [RL16] one cycle per product: valid left unused; the code still drives it from the output buffer
// [RL17] optional clear resets multiplier state synchronously
// [RL18] clear input exists only when enabled; the code keeps sclr and masks it with CLR_EN
// [RL19] everything sampled and updated on one clock
// [RL20] valid stays low until last partial product added
package mlm_pkg;

    // ------------------------------------------------------------
    // widths and build options
    // ------------------------------------------------------------
    localparam int DW = 8; // multiplicand width
    localparam int CW = 8; // coefficient width
    localparam int SW = 2; // select width
    localparam int NC = 4; // stored coefficients
    localparam int RW = 16; // product width
    localparam int DIG = 2; // multiplicand bits per table lookup
    localparam int NV = 4; // table entries per coefficient
    localparam int NDIG = 4; // lookups per product
    localparam int CPP = 4; // cycles_per_product_param
    localparam int DPC = 1; // lookups per cycle
    localparam int TW = 11; // table entry width
    localparam bit DATA_SGN = 1'b1; // multiplicand is two's complement
    localparam bit COEF_SGN = 1'b1; // coefficients are two's complement
    localparam bit LOAD_EN = 1'b1; // coefficient loading built in
    localparam bit CLR_EN = 1'b1; // synchronous clear built in
    localparam logic [2:0] INIT_COEF = 3'h1; // first coefficient, 0..4
    localparam logic [CW-1:0] OTHER_COEF = 8'h00; // other coefficients
    localparam logic [1:0] LAST_POS = 2'h3; // lookup index of last step
    localparam logic [1:0] BUF_FULL = 2'h2; // buffer word count when full

    // legal width checks
    localparam bit DW_OK = (DW >= 2 && DW <= 8) || DW == 16 || DW == 24 || DW == 32;
    localparam bit CW_OK = (CW >= 2 && CW <= 8) || CW == 16 || CW == 24;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [TW-1:0] mlm_ent_t;
    typedef logic [NC-1:0][NV-1:0][TW-1:0] mlm_tab_t;

    // product word carried through the output buffer
    typedef struct packed {
        logic [RW-1:0] value;
    } mlm_prod_t;

    // product engine states
    typedef enum logic [1:0] {
        MLM_IDLE = 2'b00,
        MLM_RUN = 2'b01,
        MLM_HOLD = 2'b10
    } mlm_state_t;

    // whole state of the multiplier core
    typedef struct packed {
        mlm_state_t st;
        logic [DW-1:0] shreg; // multiplicand bits still to use
        logic [RW-1:0] acc; // running sum of partial products
        logic [1:0] pos; // lookup index of this step
        logic [SW-1:0] sel_op; // coefficient held for this product
        logic dneg; // multiplicand was negative
        mlm_tab_t tab; // multiples of every coefficient
        logic ld_done; // no coefficient load running
        logic [1:0] ld_idx; // table entry being written
        logic [SW-1:0] ld_sel; // coefficient being written
        logic [CW-1:0] ld_val; // value being written
    } mlm_core_t;

    // whole state of the two entry buffer
    typedef struct packed {
        mlm_prod_t [1:0] mem;
        logic wr;
        logic rd;
        logic [1:0] cnt;
    } mlm_buf_t;

    // ------------------------------------------------------------
    // table helpers
    // ------------------------------------------------------------
    // k times a coefficient, extended by its representation
    function automatic mlm_ent_t mk_ent(input logic [CW-1:0] c, input int k);
        mlm_ent_t e;
        e = {{(TW-CW){c[CW-1] & COEF_SGN}}, c};
        return e * TW'(k);
    endfunction

    // table entry widened to the product width
    function automatic logic [RW-1:0] ext_rw(input mlm_ent_t e);
        return {{(RW-TW){e[TW-1] & COEF_SGN}}, e};
    endfunction

    // table contents after reset
    function automatic mlm_tab_t init_tab();
        mlm_tab_t t;
        t = '0;
        for (int s = 0; s < NC; s++)
            for (int k = 0; k < NV; k++)
                t[s][k] = mk_ent((s == 0) ? CW'(INIT_COEF) : OTHER_COEF, k);
        return t;
    endfunction

    localparam mlm_tab_t TAB_RST = init_tab();
    localparam mlm_core_t CORE_RST = '{st: MLM_IDLE, tab: TAB_RST, ld_done: 1'b1,
        default: '0};

endpackage

// ---- mlm_skid.sv ----
// two entry product buffer between the multiplier and its receiver
`timescale 1ns/1ps
module mlm_skid (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire mlm_pkg::mlm_prod_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output mlm_pkg::mlm_prod_t out_data
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    mlm_pkg::mlm_buf_t s_r; // registered state
    mlm_pkg::mlm_buf_t s_nxt; // next state
    logic wr_en; // word taken this cycle
    logic rd_en; // word given this cycle

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // ring of two words, count tells full and empty
    always_comb
    begin
        s_nxt = s_r;
        in_ready = (s_r.cnt != mlm_pkg::BUF_FULL);
        out_valid = (s_r.cnt != 2'h0);
        out_data = s_r.mem[s_r.rd];
        wr_en = in_valid && in_ready;
        rd_en = out_valid && out_ready;
        if (wr_en)
        begin
            // store at write slot
            s_nxt.mem[s_r.wr] = in_data;
            s_nxt.wr = ~s_r.wr;
        end
        if (rd_en)
        begin
            // step read slot
            s_nxt.rd = ~s_r.rd;
        end
        s_nxt.cnt = s_r.cnt + {1'b0, wr_en} - {1'b0, rd_en};
        if (clr)
        begin
            // drop every held word
            s_nxt.cnt = 2'h0;
            s_nxt.wr = 1'b0;
            s_nxt.rd = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

endmodule // mlm_skid

// ---- mlm_mult.sv ----
// lookup table constant coefficient multiplier with loadable coefficients
`timescale 1ns/1ps
module mlm_mult (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [mlm_pkg::DW-1:0] data_in,
    input wire logic op_start,
    input wire logic [mlm_pkg::SW-1:0] sel,
    input wire logic [mlm_pkg::CW-1:0] coeff_in,
    input wire logic coeff_load,
    input wire logic sclr,
    output logic data_ready,
    output logic [mlm_pkg::RW-1:0] product,
    output logic product_valid,
    input wire logic product_ready,
    output logic load_done
);

    // ------------------------------------------------------------
    // state and working signals
    // ------------------------------------------------------------
    mlm_pkg::mlm_core_t s_r; // registered state
    mlm_pkg::mlm_core_t s_nxt; // next state
    logic clr; // clear seen and built in
    logic ld_go; // load request taken
    logic [mlm_pkg::DW-1:0] src; // multiplicand bits used this cycle
    logic [mlm_pkg::SW-1:0] sel_use; // coefficient used this cycle
    logic [mlm_pkg::DIG-1:0] dig; // current lookup index
    logic [mlm_pkg::RW-1:0] sum; // sum after this cycle's lookups
    logic [mlm_pkg::RW-1:0] fin; // sum with sign correction
    logic neg; // multiplicand negative
    logic last; // this cycle ends a product
    logic push; // product handed to buffer
    logic in_rdy; // buffer has room
    mlm_pkg::mlm_prod_t in_word; // product offered to buffer
    mlm_pkg::mlm_prod_t out_word; // product leaving buffer
    logic [mlm_pkg::RW-1:0] ref_prod; // plain product, checks only

    // clear only when the clear option is built in
    assign clr = mlm_pkg::CLR_EN && sclr; // RL18

    // load taken only when built in and no load is running
    assign ld_go = mlm_pkg::LOAD_EN && coeff_load && s_r.ld_done; // RL9 RL11

    // ------------------------------------------------------------
    // product engine and coefficient table
    // ------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        push = 1'b0;
        // one cycle per product takes data straight from the port
        src = (mlm_pkg::CPP == 1) ? data_in : s_r.shreg; // RL13 RL1
        sel_use = (mlm_pkg::CPP == 1) ? sel : s_r.sel_op; // RL7
        sum = (mlm_pkg::CPP == 1) ? '0 : s_r.acc;
        dig = '0;
        // add each looked up multiple at its weight
        for (int j = 0; j < mlm_pkg::DPC; j++)
        begin
            dig = src[j*mlm_pkg::DIG +: mlm_pkg::DIG];
            sum = sum + (mlm_pkg::ext_rw(s_r.tab[sel_use][dig])
                << (mlm_pkg::DIG * (j + int'(s_r.pos)))); // RL5
        end
        // a negative multiplicand has its top bit weight subtracted
        neg = (mlm_pkg::CPP == 1) ? data_in[mlm_pkg::DW-1] : s_r.dneg;
        fin = sum;
        if (mlm_pkg::DATA_SGN && neg)
            fin = sum - (mlm_pkg::ext_rw(s_r.tab[sel_use][1]) << mlm_pkg::DW); // RL3
        last = (mlm_pkg::CPP == 1) ||
            (s_r.st == mlm_pkg::MLM_RUN && s_r.pos == mlm_pkg::LAST_POS);
        // a held product is offered from the accumulator
        in_word.value = (s_r.st == mlm_pkg::MLM_HOLD) ? s_r.acc : fin; // RL14

        if (mlm_pkg::CPP == 1)
        begin
            // a product every clock, the strobe plays no part
            push = in_rdy; // RL13
        end
        else
        begin
            unique case (s_r.st)
                mlm_pkg::MLM_IDLE:
                begin
                    // nothing running
                    s_nxt.st = mlm_pkg::MLM_IDLE;
                end
                mlm_pkg::MLM_RUN:
                begin
                    // one lookup step, product kept back until the last
                    s_nxt.acc = sum; // RL20
                    s_nxt.shreg = s_r.shreg >> (mlm_pkg::DIG * mlm_pkg::DPC);
                    s_nxt.pos = s_r.pos + 2'h1;
                    if (last)
                    begin
                        // finished: hand over or wait for room
                        s_nxt.acc = fin;
                        push = in_rdy; // RL15
                        s_nxt.st = in_rdy ? mlm_pkg::MLM_IDLE : mlm_pkg::MLM_HOLD;
                    end
                end
                mlm_pkg::MLM_HOLD:
                begin
                    // receiver stalled, keep offering
                    push = in_rdy;
                    if (in_rdy)
                        s_nxt.st = mlm_pkg::MLM_IDLE;
                end
                default:
                begin
                    // unused code returns to rest
                    s_nxt.st = mlm_pkg::MLM_IDLE;
                end
            endcase
            if (op_start)
            begin
                // new product, anything not handed over this cycle is dropped
                s_nxt.st = mlm_pkg::MLM_RUN; // RL12
                s_nxt.shreg = data_in;
                s_nxt.acc = '0;
                s_nxt.pos = '0;
                s_nxt.sel_op = sel;
                s_nxt.dneg = mlm_pkg::DATA_SGN & data_in[mlm_pkg::DW-1]; // RL3
            end
        end

        if (!s_r.ld_done)
        begin
            // write one multiple of the new coefficient per cycle
            s_nxt.tab[s_r.ld_sel][s_r.ld_idx] =
                mlm_pkg::mk_ent(s_r.ld_val, int'(s_r.ld_idx)); // RL8 RL5
            s_nxt.ld_idx = s_r.ld_idx + 2'h1;
            if (s_r.ld_idx == mlm_pkg::LAST_POS)
                s_nxt.ld_done = 1'b1; // RL10
        end
        else if (ld_go)
        begin
            // take the value for the selected coefficient
            s_nxt.ld_done = 1'b0; // RL8
            s_nxt.ld_idx = '0;
            s_nxt.ld_sel = sel;
            s_nxt.ld_val = coeff_in;
        end

        if (clr)
        begin
            // synchronous clear of engine and load, table kept
            s_nxt.st = mlm_pkg::MLM_IDLE; // RL17
            s_nxt.acc = '0;
            s_nxt.pos = '0;
            s_nxt.ld_done = 1'b1;
            s_nxt.ld_idx = '0;
            push = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // every state bit on the one clock
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            s_r <= mlm_pkg::CORE_RST; // RL6
        else
            s_r <= s_nxt; // RL19
    end

    // ------------------------------------------------------------
    // output buffer
    // ------------------------------------------------------------
    mlm_skid u_skid (
        .core_clk(core_clk),
        .nrst(nrst),
        .clr(clr),
        .in_valid(push),
        .in_ready(in_rdy),
        .in_data(in_word),
        .out_valid(product_valid), // RL16
        .out_ready(product_ready),
        .out_data(out_word)
    );

    // product leaves from buffer flops
    assign product = out_word.value; // RL14
    assign load_done = s_r.ld_done; // RL10
    // only the one cycle mode can be held off by the buffer
    assign data_ready = (mlm_pkg::CPP == 1) ? in_rdy : 1'b1;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // plain product of the port value and the selected coefficient
    assign ref_prod = {{(mlm_pkg::RW-mlm_pkg::DW){data_in[mlm_pkg::DW-1] & mlm_pkg::DATA_SGN}},
        data_in} * mlm_pkg::ext_rw(s_r.tab[sel][1]);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    property p_widths;
        mlm_pkg::DW_OK;
    endproperty
    a_widths: assert property (p_widths) else $error("bad multiplicand width"); // RL2

    property p_cwidth;
        mlm_pkg::CW_OK && mlm_pkg::INIT_COEF <= 3'h4;
    endproperty
    a_cwidth: assert property (p_cwidth) else $error("bad coefficient setup"); // RL4

    property p_init;
        disable iff (1'b0)
        !nrst |=> (!nrst || s_r.tab[0][1][mlm_pkg::CW-1:0] == mlm_pkg::CW'(mlm_pkg::INIT_COEF));
    endproperty
    a_init: assert property (p_init) else $error("first coefficient wrong after reset"); // RL6

    property p_load_len;
        disable iff (!nrst || sclr)
        ld_go |=> !load_done [*4] ##1 load_done;
    endproperty
    a_load_len: assert property (p_load_len) else $error("load done timing wrong"); // RL10

    property p_load_wr;
        disable iff (!nrst || sclr)
        ld_go |-> ##5 s_r.tab[$past(sel, 5)][1][mlm_pkg::CW-1:0] == $past(coeff_in, 5);
    endproperty
    a_load_wr: assert property (p_load_wr) else $error("coefficient not written"); // RL8

    property p_load_ign;
        (coeff_load && !load_done && !sclr) |=> $stable(s_r.ld_val) && $stable(s_r.ld_sel);
    endproperty
    a_load_ign: assert property (p_load_ign) else $error("load taken while busy"); // RL11

    property p_busy;
        disable iff (!nrst || sclr)
        op_start |=> (s_r.st == mlm_pkg::MLM_RUN && !push) [*3];
    endproperty
    a_busy: assert property (p_busy) else $error("product handed over early"); // RL20

    property p_result;
        disable iff (!nrst)
        (op_start && load_done && !coeff_load) ##1
            (!op_start && !sclr && in_rdy && !coeff_load) [*4]
            |-> push && in_word.value == $past(ref_prod, 4);
    endproperty
    a_result: assert property (p_result) else $error("product value wrong"); // RL15

    property p_hold;
        (product_valid && !product_ready && !sclr) |=> product_valid && $stable(product);
    endproperty
    a_hold: assert property (p_hold) else $error("valid product dropped"); // RL15

    property p_clear;
        sclr |=> s_r.st == mlm_pkg::MLM_IDLE && !product_valid && load_done;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not reset state"); // RL17

    // a start reloads the engine from the port, whatever was running, unless clear is high in the same cycle
    property p_restart;
        disable iff (!nrst || sclr)
        op_start |=> s_r.st == mlm_pkg::MLM_RUN && s_r.pos == 2'h0 &&
            s_r.shreg == $past(data_in);
    endproperty
    a_restart: assert property (p_restart) else $error("start did not restart product"); // RL12

    // outside the one cycle mode, nothing is offered to the buffer while the engine rests
    property p_idle_quiet;
        (mlm_pkg::CPP != 1 && s_r.st == mlm_pkg::MLM_IDLE) |-> !push;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("product offered while idle"); // RL15

endmodule // mlm_mult

// ---- mlm_sink.sv ----
// receiving user logic model that takes products and may stall
`timescale 1ns/1ps
module mlm_sink (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [1:0] sink_mode,
    input wire logic [mlm_pkg::RW-1:0] product,
    input wire logic product_valid,
    output logic product_ready,
    output logic got,
    output logic [mlm_pkg::RW-1:0] got_val
);
    // ------------------------------------------------------------
    // ready: 0 prompt, 1 random stalls, 2 stalled
    // ------------------------------------------------------------
    // ready changes just after the falling edge, never on the sampling edge
    always @(negedge core_clk or negedge nrst)
    begin
        if (!nrst)
            product_ready <= 1'b0;
        else if (sink_mode == 2'h0)
            product_ready <= 1'b1;
        else if (sink_mode == 2'h1)
            product_ready <= 1'($urandom);
        else
            product_ready <= 1'b0;
    end

    // ------------------------------------------------------------
    // capture
    // ------------------------------------------------------------
    // a word is taken only at an edge with valid and ready both high
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            got <= 1'b0;
        else
            got <= product_valid && product_ready;
        got_val <= product;
    end
endmodule // mlm_sink

// ---- mlm_tb.sv ----
// self-checking bench for the lookup multiplier
`timescale 1ns/1ps
`define CHK(nm, ex, sn) \
    begin \
        checks_done++; \
        if ((sn) !== (ex)) \
        begin \
            n_fail++; \
            $display("wrong value %s expected %h seen %h", nm, ex, sn); \
        end \
    end
module testbench;
    // ------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------
    logic core_clk = 1'b0; // 50 MHz clock
    logic nrst = 1'b0; // async reset, active low
    logic [mlm_pkg::DW-1:0] data_in = '0;
    logic op_start = 1'b0;
    logic [mlm_pkg::SW-1:0] sel = '0;
    logic [mlm_pkg::CW-1:0] coeff_in = '0;
    logic coeff_load = 1'b0;
    logic sclr = 1'b0;
    logic data_ready;
    logic [mlm_pkg::RW-1:0] product;
    logic product_valid;
    logic product_ready;
    logic load_done;
    logic [1:0] sink_mode = 2'h0; // receiver behaviour
    logic got;
    logic [mlm_pkg::RW-1:0] got_val;
    int n_fail = 0;
    int checks_done = 0;
    int coef [4]; // coefficient model
    logic [mlm_pkg::RW-1:0] exp_q [$]; // products still owed, in order
    logic [mlm_pkg::RW-1:0] exp_v;
    logic [7:0] vals [4] = '{8'h80, 8'h7f, 8'hff, 8'h03}; // boundary values

    always #10 core_clk = ~core_clk;

    mlm_mult mlm_mult_i (
        .core_clk(core_clk),
        .nrst(nrst),
        .data_in(data_in),
        .op_start(op_start),
        .sel(sel),
        .coeff_in(coeff_in),
        .coeff_load(coeff_load),
        .sclr(sclr),
        .data_ready(data_ready),
        .product(product),
        .product_valid(product_valid),
        .product_ready(product_ready),
        .load_done(load_done)
    );

    mlm_sink mlm_sink_i (
        .core_clk(core_clk),
        .nrst(nrst),
        .sink_mode(sink_mode),
        .product(product),
        .product_valid(product_valid),
        .product_ready(product_ready),
        .got(got),
        .got_val(got_val)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // two's complement product modulo the product width
    function automatic logic [mlm_pkg::RW-1:0] mul(input logic [7:0] d, input int c);
        int p;
        p = $signed(d) * c;
        return p[mlm_pkg::RW-1:0];
    endfunction

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one start pulse; inputs scrambled afterwards since only the start edge counts
    task automatic start(input logic [7:0] d, input logic [1:0] s);
        op_start = 1'b1;
        data_in = d;
        sel = s;
        exp_q.push_back(mul(d, coef[s]));
        tick(1);
        op_start = 1'b0;
        data_in = 8'($urandom);
        sel = 2'($urandom);
    endtask

    // load with a refused second load while the first is written
    task automatic load(input logic [7:0] v, input logic [1:0] s);
        coeff_load = 1'b1;
        coeff_in = v;
        sel = s;
        tick(1);
        coeff_load = 1'b0;
        coef[s] = $signed(v);
        `CHK("load_done", 1'b0, load_done)
        tick(1);
        coeff_load = 1'b1;
        coeff_in = ~v;
        sel = s + 2'h1;
        tick(1);
        coeff_load = 1'b0;
        tick(1);
        `CHK("load_done", 1'b0, load_done)
        tick(1);
        `CHK("load_done", 1'b1, load_done)
    endtask

    // bounded wait until every owed product has arrived
    task automatic drain();
        int i;
        i = 0;
        while ((exp_q.size() > 0 || product_valid !== 1'b0) && i < 300)
        begin
            tick(1);
            i++;
        end
        if (i >= 300)
        begin
            n_fail++;
            stop_test();
        end
        tick(1);
    endtask

    // ------------------------------------------------------------
    // product monitor
    // ------------------------------------------------------------
    // every word taken by the receiver must be the next one owed
    always @(posedge core_clk)
    begin
        if (got === 1'b1)
        begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
            `CHK("product", exp_v, got_val)
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(19680));
        coef[0] = int'(mlm_pkg::INIT_COEF);
        for (int s = 1; s < 4; s++)
            coef[s] = $signed(mlm_pkg::OTHER_COEF);
        tick(5);
        `CHK("product_valid", 1'b0, product_valid)
        `CHK("load_done", 1'b1, load_done)
        `CHK("data_ready", 1'b1, data_ready)
        tick(1);
        nrst = 1'b1;
        // latency: valid low until the last step, one word per handshake
        start(8'h85, 2'h0);
        tick(3);
        `CHK("product_valid", 1'b0, product_valid)
        tick(1);
        `CHK("product_valid", 1'b1, product_valid)
        tick(1);
        `CHK("product_valid", 1'b0, product_valid)
        drain();
        start(8'h7f, 2'h1);
        drain();
        // load every coefficient, then multiply each by boundary and random data
        for (int s = 0; s < 4; s++)
            load((s == 2) ? 8'($urandom) : vals[s], 2'(s));
        for (int s = 0; s < 4; s++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                start((k == 3) ? 8'($urandom) : vals[k], 2'(s));
                drain();
            end
        end
        // restart two cycles in: only the second product may appear
        start(8'h11, 2'h0);
        void'(exp_q.pop_back());
        tick(1);
        start(8'h93, 2'h1);
        drain();
        // full rate, one start every four cycles
        repeat (6)
        begin
            start(8'($urandom), 2'($urandom));
            tick(3);
        end
        `CHK("data_ready", 1'b1, data_ready)
        drain();
        // receiver stalls: buffer fills, engine holds, nothing lost
        sink_mode = 2'h2;
        repeat (3)
        begin
            start(8'($urandom), 2'($urandom));
            tick(4);
        end
        tick(2);
        `CHK("product_valid", 1'b1, product_valid)
        sink_mode = 2'h1;
        drain();
        // clear with full buffer and a running product
        sink_mode = 2'h2;
        repeat (2)
        begin
            start(8'($urandom), 2'($urandom));
            tick(4);
        end
        start(8'h42, 2'h2);
        sclr = 1'b1;
        tick(1);
        sclr = 1'b0;
        `CHK("product_valid", 1'b0, product_valid)
        exp_q.delete();
        // clear in mid-load frees the load port
        coeff_load = 1'b1;
        coeff_in = 8'h55;
        sel = 2'h3;
        tick(1);
        coeff_load = 1'b0;
        tick(1);
        sclr = 1'b1;
        tick(1);
        sclr = 1'b0;
        `CHK("load_done", 1'b1, load_done)
        sink_mode = 2'h0;
        tick(10);
        load(8'h9c, 2'h3);
        start(8'hc3, 2'h3);
        drain();
        start(8'h3c, 2'h1);
        drain();
        tick(10);
        `CHK("owed products", 0, exp_q.size())
        stop_test();
    end
endmodule // testbench
